// ---- rtl/fps_pwm_subcmd.v ----
// subcommand decoder, regulator control and two switch pwm generators of a battery monitor
// assumes an avalon-mm master on core_clk_i; one clock, asynchronous active-low reset
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
`include "fps_consts.vh"

module fps_pwm_subcmd #(
    parameter [31:0] REPEAT_WINDOW_CYC = `FPS_REPEAT_WINDOW_CYC,
    parameter [15:0] KEY0 = `FPS_KEY0_DEFAULT,
    parameter [15:0] KEY1 = `FPS_KEY1_DEFAULT
) (
    input wire core_clk_i,
    input wire nrst_i,
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    output reg thermistor_bias_hold_o,
    output reg aux_regulator_output_o,
    output reg [2:0] ldo_voltage_select_o,
    output reg [5:0] ldo_decivolts_o,
    output reg discharge_switch_pwm_o,
    output reg charge_switch_pwm_o,
    output reg clear_charge_accumulator_o,
    output reg enter_lowest_power_o,
    output reg shutdown_start_o,
    output reg shutdown_skip_delay_o,
    output reg device_reset_o,
    output reg autonomous_switch_flag_o,
    output reg unlocked_access_o,
    output reg config_edit_o,
    output reg sleep_allowed_o
);

    // subcommand tracker states
    localparam [1:0] SQ_IDLE = 2'h0;
    localparam [1:0] SQ_LOW1 = 2'h1;
    localparam [1:0] SQ_SHD1 = 2'h2;
    localparam [1:0] SQ_SHD2 = 2'h3;

    reg ack_r;
    reg [7:0] aux_regulator_output_r;
    reg [15:0] dsg_pwm_r;
    reg [15:0] chg_pwm_r;
    reg [7:0] dsg_lo_r;
    reg [7:0] chg_lo_r;
    reg [1:0] seq_r;
    reg [31:0] win_r;
    reg [1:0] key_st_r;
    reg [15:0] key_word_r;

    // write lands at the edge where waitrequest is low; read data loads one edge
    // earlier so that it already stands when the master takes it
    wire wr = avs_write_i && ack_r;
    wire rd = avs_read_i && !ack_r;
    wire [15:0] wd16 = avs_writedata_i[15:0];
    wire cmd_wr = wr && (avs_address_i == `FPS_ADDR_SUBCMD) && (&avs_byteenable_i[1:0]);
    wire [15:0] cmd = wd16;
    wire unl = unlocked_access_o;

    // one wait cycle per access: request taken on the edge where waitrequest is low
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;

    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read_i || avs_write_i) && !ack_r;
        end
    end

    // pwm register write: low byte staged, upper byte commits both unless the on or off field would be zero
    function [15:0] pwm_commit;
        input [15:0] cur;
        input [7:0] lo;
        input [7:0] hi;
        reg [15:0] cand;
        begin
            cand = {hi, lo};
            if (cand[`FPS_PWM_ON_MSB:`FPS_PWM_ON_LSB] == 7'h00 ||
                    cand[`FPS_PWM_OFF_MSB:0] == 8'h00) begin
                pwm_commit = cur;
            end else begin
                pwm_commit = cand;
            end
        end
    endfunction

    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aux_regulator_output_r <= `FPS_REG_RESET;
            dsg_pwm_r <= `FPS_PWM_RESET;
            chg_pwm_r <= `FPS_PWM_RESET;
            dsg_lo_r <= 8'h00;
            chg_lo_r <= 8'h00;
        end else if (wr) begin
            if (avs_address_i == `FPS_ADDR_AUX_REGULATOR_OUTPUT) begin
                if (avs_byteenable_i[0]) begin
                    aux_regulator_output_r <= avs_writedata_i[7:0] & `FPS_REG_MASK;
                end
            end else if (avs_address_i == `FPS_ADDR_DSG_PWM) begin
                if (avs_byteenable_i[0]) begin
                    dsg_lo_r <= avs_writedata_i[7:0];
                end
                if (avs_byteenable_i[1]) begin
                    dsg_pwm_r <= pwm_commit(dsg_pwm_r,
                        avs_byteenable_i[0] ? avs_writedata_i[7:0] : dsg_lo_r,
                        avs_writedata_i[15:8]);
                end
            end else if (avs_address_i == `FPS_ADDR_CHG_PWM) begin
                if (avs_byteenable_i[0]) begin
                    chg_lo_r <= avs_writedata_i[7:0];
                end
                if (avs_byteenable_i[1]) begin
                    chg_pwm_r <= pwm_commit(chg_pwm_r,
                        avs_byteenable_i[0] ? avs_writedata_i[7:0] : chg_lo_r,
                        avs_writedata_i[15:8]);
                end
            end
        end
    end

    // regulator outputs
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            thermistor_bias_hold_o <= 1'b0;
            aux_regulator_output_o <= 1'b0;
            ldo_voltage_select_o <= 3'h0;
            ldo_decivolts_o <= `FPS_MV_1V8;
        end else begin
            thermistor_bias_hold_o <= aux_regulator_output_r[`FPS_REG_TS_BIT];
            aux_regulator_output_o <= aux_regulator_output_r[`FPS_REG_EN_BIT];
            ldo_voltage_select_o <= aux_regulator_output_r[`FPS_REG_VSEL_MSB:0];
            case (aux_regulator_output_r[`FPS_REG_VSEL_MSB:0])
                3'h4: ldo_decivolts_o <= `FPS_MV_2V5;
                3'h5: ldo_decivolts_o <= `FPS_MV_3V0;
                3'h6: ldo_decivolts_o <= `FPS_MV_3V3;
                3'h7: ldo_decivolts_o <= `FPS_MV_5V0;
                default: ldo_decivolts_o <= `FPS_MV_1V8;
            endcase
        end
    end

    // pwm generators; step prescaler then step counter per phase
    reg [14:0] dsg_pre_r;
    reg [7:0] dsg_cnt_r;
    reg [14:0] chg_pre_r;
    reg [7:0] chg_cnt_r;
    localparam [31:0] ON_STEP_W = `FPS_ON_STEP_CYC;
    localparam [31:0] DSG_OFF_STEP_W = `FPS_DSG_OFF_STEP_CYC;
    localparam [31:0] CHG_OFF_STEP_W = `FPS_CHG_OFF_STEP_CYC;
    // all step counts fit the 15-bit prescaler
    wire [14:0] dsg_step = dsg_pwm_r[`FPS_PWM_EN_BIT] && discharge_switch_pwm_o ?
        ON_STEP_W[14:0] : DSG_OFF_STEP_W[14:0];
    wire [14:0] chg_step = charge_switch_pwm_o ?
        ON_STEP_W[14:0] : CHG_OFF_STEP_W[14:0];
    wire [7:0] dsg_len = discharge_switch_pwm_o ?
        {1'b0, dsg_pwm_r[`FPS_PWM_ON_MSB:`FPS_PWM_ON_LSB]} : dsg_pwm_r[7:0];
    wire [7:0] chg_len = charge_switch_pwm_o ?
        {1'b0, chg_pwm_r[`FPS_PWM_ON_MSB:`FPS_PWM_ON_LSB]} : chg_pwm_r[7:0];

    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dsg_pre_r <= 15'h0000;
            dsg_cnt_r <= 8'h00;
            discharge_switch_pwm_o <= 1'b0;
        end else if (!dsg_pwm_r[`FPS_PWM_EN_BIT]) begin
            dsg_pre_r <= 15'h0000;
            dsg_cnt_r <= 8'h00;
            discharge_switch_pwm_o <= 1'b0;
        end else if (dsg_pre_r + 15'h0001 < dsg_step) begin
            dsg_pre_r <= dsg_pre_r + 15'h0001;
        end else begin
            dsg_pre_r <= 15'h0000;
            if (dsg_cnt_r + 8'h01 < dsg_len) begin
                dsg_cnt_r <= dsg_cnt_r + 8'h01;
            end else begin
                dsg_cnt_r <= 8'h00;
                discharge_switch_pwm_o <= !discharge_switch_pwm_o;
            end
        end
    end

    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chg_pre_r <= 15'h0000;
            chg_cnt_r <= 8'h00;
            charge_switch_pwm_o <= 1'b0;
        end else if (!chg_pwm_r[`FPS_PWM_EN_BIT]) begin
            chg_pre_r <= 15'h0000;
            chg_cnt_r <= 8'h00;
            charge_switch_pwm_o <= 1'b0;
        end else if (chg_pre_r + 15'h0001 < chg_step) begin
            chg_pre_r <= chg_pre_r + 15'h0001;
        end else begin
            chg_pre_r <= 15'h0000;
            if (chg_cnt_r + 8'h01 < chg_len) begin
                chg_cnt_r <= chg_cnt_r + 8'h01;
            end else begin
                chg_cnt_r <= 8'h00;
                charge_switch_pwm_o <= !charge_switch_pwm_o;
            end
        end
    end

    // subcommand decoder; repeat window counts down from the last matching command
    wire win_live = (win_r != 32'h0000_0000);

    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            seq_r <= SQ_IDLE;
            win_r <= 32'h0000_0000;
            key_st_r <= 2'h0;
            key_word_r <= 16'h0000;
            clear_charge_accumulator_o <= 1'b0;
            enter_lowest_power_o <= 1'b0;
            shutdown_start_o <= 1'b0;
            shutdown_skip_delay_o <= 1'b0;
            device_reset_o <= 1'b0;
            autonomous_switch_flag_o <= 1'b0;
            unlocked_access_o <= 1'b0;
            config_edit_o <= 1'b0;
            sleep_allowed_o <= 1'b1;
        end else begin
            clear_charge_accumulator_o <= 1'b0;
            shutdown_start_o <= 1'b0;
            shutdown_skip_delay_o <= 1'b0;
            device_reset_o <= 1'b0;
            if (win_live) begin
                win_r <= win_r - 32'h0000_0001;
            end else begin
                seq_r <= SQ_IDLE;
            end
            if (cmd_wr) begin
                // any other command breaks a repeat sequence
                seq_r <= SQ_IDLE;
                win_r <= 32'h0000_0000;
                if (key_st_r == 2'h1) begin
                    key_st_r <= 2'h2;
                    key_word_r <= cmd;
                end else if (key_st_r == 2'h2) begin
                    key_st_r <= 2'h0;
                    if (key_word_r == KEY0 && cmd == KEY1) begin
                        unlocked_access_o <= 1'b1;
                    end
                end else if (cmd == `FPS_CMD_CLR_CHARGE) begin
                    clear_charge_accumulator_o <= 1'b1;
                end else if (cmd == `FPS_CMD_LEAVE_LOW) begin
                    enter_lowest_power_o <= 1'b0;
                end else if (cmd == `FPS_CMD_ENTER_LOW) begin
                    if (seq_r == SQ_LOW1 && win_live) begin
                        enter_lowest_power_o <= 1'b1;
                    end else begin
                        seq_r <= SQ_LOW1;
                        win_r <= REPEAT_WINDOW_CYC;
                    end
                end else if (cmd == `FPS_CMD_SHUTDOWN) begin
                    if (seq_r == SQ_SHD1 && win_live) begin
                        shutdown_start_o <= 1'b1;
                        seq_r <= SQ_SHD2;
                        win_r <= REPEAT_WINDOW_CYC;
                    end else if (seq_r == SQ_SHD2 && win_live) begin
                        shutdown_skip_delay_o <= 1'b1;
                    end else begin
                        seq_r <= SQ_SHD1;
                        win_r <= REPEAT_WINDOW_CYC;
                    end
                end else if (cmd == `FPS_CMD_SLEEP_ALLOW) begin
                    sleep_allowed_o <= 1'b1;
                end else if (cmd == `FPS_CMD_SLEEP_BLOCK) begin
                    sleep_allowed_o <= 1'b0;
                end else if (cmd == `FPS_CMD_UNLOCK_KEY && !unl) begin
                    key_st_r <= 2'h1;
                end else if (unl) begin
                    // locked level falls through here and changes nothing
                    if (cmd == `FPS_CMD_RESET) begin
                        device_reset_o <= 1'b1;
                    end else if (cmd == `FPS_CMD_AUTONOMY) begin
                        autonomous_switch_flag_o <= !autonomous_switch_flag_o;
                    end else if (cmd == `FPS_CMD_LOCK) begin
                        unlocked_access_o <= 1'b0;
                        config_edit_o <= 1'b0;
                    end else if (cmd == `FPS_CMD_CFG_ENTER) begin
                        config_edit_o <= 1'b1;
                    end else if (cmd == `FPS_CMD_CFG_LEAVE) begin
                        config_edit_o <= 1'b0;
                    end
                end
            end
        end
    end

    // read data
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (rd) begin
            if (avs_address_i == `FPS_ADDR_AUX_REGULATOR_OUTPUT) begin
                avs_readdata_o <= {24'h000000, aux_regulator_output_r};
            end else if (avs_address_i == `FPS_ADDR_DSG_PWM) begin
                avs_readdata_o <= {16'h0000, dsg_pwm_r};
            end else if (avs_address_i == `FPS_ADDR_CHG_PWM) begin
                avs_readdata_o <= {16'h0000, chg_pwm_r};
            end else if (avs_address_i == `FPS_ADDR_SUBCMD) begin
                avs_readdata_o <= 32'h0000_0000;
            end else if (avs_address_i == `FPS_ADDR_STATUS) begin
                avs_readdata_o <= {24'h000000, discharge_switch_pwm_o, charge_switch_pwm_o,
                    sleep_allowed_o, config_edit_o, unlocked_access_o,
                    autonomous_switch_flag_o, enter_lowest_power_o, seq_r == SQ_SHD2};
            end else begin
                avs_readdata_o <= `FPS_ADDR_UNMAPPED;
            end
        end
    end

endmodule

// ---- inc/fps_consts.vh ----
// register offsets, field positions, reset values, command codes and timing counts
// of the switch pwm and subcommand block; included by its design file, the assertion file and the test bench
`ifndef FPS_CONSTS_VH
`define FPS_CONSTS_VH

// word addresses on the avalon bus, one word each
`define FPS_ADDR_AUX_REGULATOR_OUTPUT 4'h0
`define FPS_ADDR_DSG_PWM 4'h1
`define FPS_ADDR_CHG_PWM 4'h2
`define FPS_ADDR_SUBCMD 4'h3
`define FPS_ADDR_STATUS 4'h4
`define FPS_ADDR_KEY 4'h5
`define FPS_ADDR_UNMAPPED 32'hDEAD_BEEF

// regulator control fields
`define FPS_REG_TS_BIT 4
`define FPS_REG_EN_BIT 3
`define FPS_REG_VSEL_MSB 2
`define FPS_REG_RESET 8'h00
`define FPS_REG_MASK 8'h1F

// pwm register fields
`define FPS_PWM_EN_BIT 15
`define FPS_PWM_ON_MSB 14
`define FPS_PWM_ON_LSB 8
`define FPS_PWM_OFF_MSB 7
`define FPS_PWM_RESET 16'h0000

// regulator voltage codes in tenths of a volt
`define FPS_MV_1V8 6'h12
`define FPS_MV_2V5 6'h19
`define FPS_MV_3V0 6'h1E
`define FPS_MV_3V3 6'h21
`define FPS_MV_5V0 6'h32

// command-only subcommand codes
`define FPS_CMD_CLR_CHARGE 16'h0005
`define FPS_CMD_LEAVE_LOW 16'h000E
`define FPS_CMD_ENTER_LOW 16'h000F
`define FPS_CMD_SHUTDOWN 16'h0010
`define FPS_CMD_RESET 16'h0012
`define FPS_CMD_AUTONOMY 16'h0022
`define FPS_CMD_LOCK 16'h0030
`define FPS_CMD_UNLOCK_KEY 16'h0035
`define FPS_CMD_CFG_ENTER 16'h0090
`define FPS_CMD_CFG_LEAVE 16'h0092
`define FPS_CMD_SLEEP_ALLOW 16'h0099
`define FPS_CMD_SLEEP_BLOCK 16'h009A

// timing, clock 50 MHz
`define FPS_CLK_HZ 50000000
`define FPS_REPEAT_WINDOW_S 4
`define FPS_REPEAT_WINDOW_CYC (`FPS_REPEAT_WINDOW_S * `FPS_CLK_HZ)
// pwm steps in nanoseconds; step counts round down
`define FPS_ON_STEP_NS 30520
`define FPS_DSG_OFF_STEP_NS 122100
`define FPS_CHG_OFF_STEP_NS 488400
`define FPS_CLK_NS 20
`define FPS_ON_STEP_CYC (`FPS_ON_STEP_NS / `FPS_CLK_NS)
`define FPS_DSG_OFF_STEP_CYC (`FPS_DSG_OFF_STEP_NS / `FPS_CLK_NS)
`define FPS_CHG_OFF_STEP_CYC (`FPS_CHG_OFF_STEP_NS / `FPS_CLK_NS)

// default unlock key words, arbitrary values
`define FPS_KEY0_DEFAULT 16'h1234
`define FPS_KEY1_DEFAULT 16'h5678

`endif

// ---- tb/fps_pwm_subcmd_asserts.sv ----
// concurrent checks on the top ports of the switch pwm and subcommand block
// assumes one clock; a subcommand is taken at the edge where waitrequest is low
`timescale 1ns/100ps
`include "fps_consts.vh"
module fps_chk (
    input wire core_clk_i,
    input wire nrst_i,
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_writedata_i,
    input wire avs_waitrequest_o,
    input wire thermistor_bias_hold_o,
    input wire aux_regulator_output_o,
    input wire [2:0] ldo_voltage_select_o,
    input wire clear_charge_accumulator_o,
    input wire enter_lowest_power_o,
    input wire shutdown_start_o,
    input wire device_reset_o,
    input wire autonomous_switch_flag_o,
    input wire unlocked_access_o,
    input wire config_edit_o,
    input wire sleep_allowed_o
);
    wire tk = avs_write_i && !avs_waitrequest_o;
    wire sc = tk && avs_address_i == `FPS_ADDR_SUBCMD && avs_byteenable_i[1:0] == 2'h3;
    wire [15:0] c = avs_writedata_i[15:0];
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    a_wait_one: assert property (
        $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("waitrequest not one cycle");
    a_clear_pulse: assert property (
        sc && c == `FPS_CMD_CLR_CHARGE |=> clear_charge_accumulator_o)
        else $error("charge clear pulse missing");
    a_low_leave: assert property (
        sc && c == `FPS_CMD_LEAVE_LOW |=> !enter_lowest_power_o)
        else $error("lowest power not left");
    a_shut_cause: assert property (
        $rose(shutdown_start_o) |-> $past(sc && c == `FPS_CMD_SHUTDOWN))
        else $error("shutdown without command");
    a_reset_locked: assert property (
        sc && c == `FPS_CMD_RESET && !unlocked_access_o |=> !device_reset_o)
        else $error("reset taken while locked");
    a_reset_cause: assert property (
        $rose(device_reset_o) |-> $past(sc && c == `FPS_CMD_RESET && unlocked_access_o))
        else $error("reset without command");
    a_lock_cmd: assert property (
        sc && c == `FPS_CMD_LOCK && unlocked_access_o |=> !unlocked_access_o)
        else $error("lock command ignored");
    a_auto_toggle: assert property (
        sc && c == `FPS_CMD_AUTONOMY && unlocked_access_o |=> $changed(autonomous_switch_flag_o))
        else $error("autonomy flag not toggled");
    a_locked_ignore: assert property (
        sc && !unlocked_access_o && (c == `FPS_CMD_AUTONOMY || c == `FPS_CMD_CFG_ENTER)
        |=> $stable(autonomous_switch_flag_o) && $stable(config_edit_o))
        else $error("locked command changed state");
    a_sleep_cmd: assert property (
        sc && (c == `FPS_CMD_SLEEP_ALLOW || c == `FPS_CMD_SLEEP_BLOCK)
        |=> sleep_allowed_o == $past(c == `FPS_CMD_SLEEP_ALLOW))
        else $error("sleep permission wrong");
    a_aux_regulator_output_follow: assert property (
        tk && avs_address_i == `FPS_ADDR_AUX_REGULATOR_OUTPUT && avs_byteenable_i[0]
        |-> ##2 {thermistor_bias_hold_o, aux_regulator_output_o, ldo_voltage_select_o}
        == $past(avs_writedata_i[4:0], 2))
        else $error("regulator outputs wrong");
    c_clear: cover property (sc && c == `FPS_CMD_CLR_CHARGE);
    c_low: cover property ($rose(enter_lowest_power_o));
    c_unlock: cover property ($rose(unlocked_access_o));
    c_reset: cover property ($rose(device_reset_o));
endmodule
bind fps_pwm_subcmd fps_chk u_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
    .avs_waitrequest_o(avs_waitrequest_o), .thermistor_bias_hold_o(thermistor_bias_hold_o),
    .aux_regulator_output_o(aux_regulator_output_o),
    .ldo_voltage_select_o(ldo_voltage_select_o),
    .clear_charge_accumulator_o(clear_charge_accumulator_o),
    .enter_lowest_power_o(enter_lowest_power_o), .shutdown_start_o(shutdown_start_o),
    .device_reset_o(device_reset_o), .autonomous_switch_flag_o(autonomous_switch_flag_o),
    .unlocked_access_o(unlocked_access_o), .config_edit_o(config_edit_o),
    .sleep_allowed_o(sleep_allowed_o));

// ---- tb/fps_host_model.sv ----
// host controller model: avalon-mm master run by task calls
// assumes each call starts just after a rising edge
`timescale 1ns/100ps
module fps_host_model (
    input wire clk_i,
    input wire wait_i,
    input wire [31:0] rdata_i,
    output reg [3:0] addr_o = 4'h0,
    output reg rd_o = 1'b0,
    output reg wr_o = 1'b0,
    output reg [3:0] be_o = 4'h0,
    output reg [31:0] wd_o = 32'h00000000
);
    reg wait_s;
    reg [31:0] rdata_s;
    // mid-cycle copy equals what the next rising edge sees
    always @(negedge clk_i) begin
        wait_s <= wait_i;
        rdata_s <= rdata_i;
    end
    task xfer(input w, input [3:0] a, input [3:0] b, input [15:0] d, output [31:0] q);
        begin
            addr_o <= a;
            be_o <= b;
            wd_o <= {16'h0000, d};
            wr_o <= w;
            rd_o <= !w;
            @(posedge clk_i);
            // no limit of its own: only the bench watchdog ends a hung wait
            while (wait_s !== 1'b0) begin
                @(posedge clk_i);
            end
            q = rdata_s;
            wr_o <= 1'b0;
            rd_o <= 1'b0;
            // idle edge so the next request is a fresh rise
            @(posedge clk_i);
        end
    endtask
endmodule

// ---- tb/test_fps_pwm_subcmd.sv ----
// self-checking bench of the switch pwm and subcommand block
// assumes the host model as bus master and a short repeat window
`timescale 1ns/100ps
`include "fps_consts.vh"
module test_fps_pwm_subcmd;
    reg core_clk_i = 1'b0;
    reg nrst_i = 1'b0;
    wire [3:0] addr, be;
    wire [31:0] wd, rdata;
    wire [2:0] vsel;
    wire [5:0] dv;
    wire rd, wr, wq, therm, aux, discharge_switch, charge_switch, clr, low, sd, skip, drst, auto_f, unl, cfg, slp;
    wire [1:0] pwm = {charge_switch, discharge_switch};
    integer miscompares = 0;
    integer n_tests = 0;
    integer n_clr = 0, n_sd = 0, n_skip = 0, n_rst = 0;
    reg [31:0] q;
    fps_pwm_subcmd #(.REPEAT_WINDOW_CYC(32'd50)) dut (.core_clk_i(core_clk_i),
        .nrst_i(nrst_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_byteenable_i(be), .avs_writedata_i(wd), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wq), .thermistor_bias_hold_o(therm), .aux_regulator_output_o(aux),
        .ldo_voltage_select_o(vsel), .ldo_decivolts_o(dv), .discharge_switch_pwm_o(discharge_switch),
        .charge_switch_pwm_o(charge_switch), .clear_charge_accumulator_o(clr), .enter_lowest_power_o(low),
        .shutdown_start_o(sd), .shutdown_skip_delay_o(skip), .device_reset_o(drst),
        .autonomous_switch_flag_o(auto_f), .unlocked_access_o(unl), .config_edit_o(cfg),
        .sleep_allowed_o(slp));
    fps_host_model host (.clk_i(core_clk_i), .wait_i(wq), .rdata_i(rdata), .addr_o(addr),
        .rd_o(rd), .wr_o(wr), .be_o(be), .wd_o(wd));
    always #10 core_clk_i = ~core_clk_i;
    // pulses counted mid-cycle, away from the edge that moves them
    always @(negedge core_clk_i) begin
        n_clr = n_clr + clr;
        n_sd = n_sd + sd;
        n_skip = n_skip + skip;
        n_rst = n_rst + drst;
    end
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("BAD %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task wr16(input [3:0] a, input [3:0] b, input [15:0] d);
        host.xfer(1'b1, a, b, d, q);
    endtask
    task cmd(input [15:0] c);
        wr16(`FPS_ADDR_SUBCMD, 4'h3, c);
    endtask
    task rd32(input [3:0] a);
        host.xfer(1'b0, a, 4'hF, 16'h0000, q);
    endtask
    task keys(input [15:0] k0, input [15:0] k1);
        begin
            cmd(`FPS_CMD_UNLOCK_KEY);
            cmd(k0);
            cmd(k1);
        end
    endtask
    task pw(input integer s, input integer h, input integer l);
        integer n;
        begin
            n = 0;
            while (pwm[s] !== 1'b0 && n < 40000) begin
                @(negedge core_clk_i);
                n = n + 1;
            end
            while (pwm[s] !== 1'b1 && n < 40000) begin
                @(negedge core_clk_i);
                n = n + 1;
            end
            n = 0;
            while (pwm[s] === 1'b1 && n < 40000) begin
                @(negedge core_clk_i);
                n = n + 1;
            end
            chk(n, h);
            n = 0;
            while (pwm[s] === 1'b0 && n < 40000) begin
                @(negedge core_clk_i);
                n = n + 1;
            end
            chk(n, l);
            @(posedge core_clk_i);
        end
    endtask
    task t_start;
        begin
            chk({slp, unl, cfg, auto_f, low, aux, therm, discharge_switch, charge_switch}, 9'h100);
            chk(dv, `FPS_MV_1V8);
            rd32(4'hF);
            chk(q, `FPS_ADDR_UNMAPPED);
        end
    endtask
    task t_locked;
        begin
            cmd(`FPS_CMD_AUTONOMY);
            cmd(`FPS_CMD_CFG_ENTER);
            cmd(`FPS_CMD_RESET);
            chk({auto_f, cfg, unl, n_rst[0]}, 0);
            cmd(`FPS_CMD_CLR_CHARGE);
            chk(n_clr, 1);
            cmd(`FPS_CMD_SLEEP_BLOCK);
            chk(slp, 0);
            cmd(`FPS_CMD_SLEEP_ALLOW);
            chk(slp, 1);
            keys(16'h0000, 16'h0000);
            chk(unl, 0);
        end
    endtask
    task t_unlocked;
        begin
            keys(`FPS_KEY0_DEFAULT, `FPS_KEY1_DEFAULT);
            chk(unl, 1);
            cmd(`FPS_CMD_AUTONOMY);
            chk(auto_f, 1);
            cmd(`FPS_CMD_AUTONOMY);
            chk(auto_f, 0);
            cmd(`FPS_CMD_CFG_ENTER);
            chk(cfg, 1);
            rd32(`FPS_ADDR_STATUS);
            chk(q, 32'h0000_0038);
            cmd(`FPS_CMD_CFG_LEAVE);
            chk(cfg, 0);
            cmd(`FPS_CMD_LOCK);
            chk(unl, 0);
        end
    endtask
    task t_repeat;
        begin
            cmd(`FPS_CMD_ENTER_LOW);
            repeat (60) @(posedge core_clk_i);
            cmd(`FPS_CMD_ENTER_LOW);
            chk(low, 0);
            cmd(`FPS_CMD_ENTER_LOW);
            chk(low, 1);
            cmd(`FPS_CMD_LEAVE_LOW);
            chk(low, 0);
            cmd(`FPS_CMD_SHUTDOWN);
            chk(n_sd, 0);
            cmd(`FPS_CMD_SHUTDOWN);
            chk(n_sd, 1);
            cmd(`FPS_CMD_SHUTDOWN);
            chk(n_skip, 1);
        end
    endtask
    task t_aux_regulator_output;
        reg [3:0] i;
        reg [4:0] v;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                v = {i[0], i[1], i[2:0]};
                wr16(`FPS_ADDR_AUX_REGULATOR_OUTPUT, 4'h1, {11'h000, v});
                // outputs register one edge after the register lands
                @(posedge core_clk_i);
                chk({therm, aux, vsel}, v);
                chk(dv, i < 4 ? `FPS_MV_1V8 : i == 4 ? `FPS_MV_2V5 : i == 5 ? `FPS_MV_3V0 :
                    i == 6 ? `FPS_MV_3V3 : `FPS_MV_5V0);
                rd32(`FPS_ADDR_AUX_REGULATOR_OUTPUT);
                chk(q, {27'h0, v});
            end
        end
    endtask
    task t_pwm;
        begin
            wr16(`FPS_ADDR_DSG_PWM, 4'h1, 16'h0001);
            repeat (10) @(posedge core_clk_i);
            chk(discharge_switch, 0);
            wr16(`FPS_ADDR_DSG_PWM, 4'h2, 16'h8100);
            pw(0, `FPS_ON_STEP_CYC, `FPS_DSG_OFF_STEP_CYC);
            wr16(`FPS_ADDR_CHG_PWM, 4'h3, 16'h8200);
            rd32(`FPS_ADDR_CHG_PWM);
            chk(q, 0);
            chk(charge_switch, 0);
            wr16(`FPS_ADDR_CHG_PWM, 4'h3, 16'h8201);
            pw(1, 2 * `FPS_ON_STEP_CYC, `FPS_CHG_OFF_STEP_CYC);
            wr16(`FPS_ADDR_DSG_PWM, 4'h3, 16'h0101);
            repeat (3) @(posedge core_clk_i);
            chk(discharge_switch, 0);
            rd32(`FPS_ADDR_DSG_PWM);
            chk(q, 32'h0101);
        end
    endtask
    task end_sim;
        begin
            if (miscompares == 0 && n_tests > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (4) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        @(posedge core_clk_i);
        t_start;
        t_locked;
        t_unlocked;
        t_repeat;
        t_aux_regulator_output;
        t_pwm;
        keys(`FPS_KEY0_DEFAULT, `FPS_KEY1_DEFAULT);
        cmd(`FPS_CMD_RESET);
        chk(n_rst, 1);
        end_sim;
    end
    initial begin
        repeat (95000) @(posedge core_clk_i);
        miscompares = miscompares + 1;
        end_sim;
    end
endmodule
